//--- bench/nvsc_ctrl_monitor.sv
/* pin timing checker for the controller
   assumes bind onto nvsc_ctrl, single clock */
`default_nettype none
module nvsc_ctrl_monitor #(
    parameter logic [15:0] RECOVERY_CYC = 16'h0008
) (
    input wire logic        i_ref_clk,
    input wire logic        i_rstn,
    input wire logic [14:0] o_addr_bus,
    input wire logic        o_chip_select_n,
    input wire logic        o_output_enable_n,
    input wire logic        o_write_enable_n,
    input wire logic [7:0]  o_data_bus,
    input wire logic        o_data_bus_oe,
    input wire logic        i_store_busy_n,
    input wire logic        o_store_busy_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] hi_cnt_q;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // cycles since the busy pin was last low
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !i_store_busy_n) hi_cnt_q <= 16'h0000;
        else if (hi_cnt_q != 16'hFFFF) hi_cnt_q <= hi_cnt_q + 16'h0001;
    end
    sequence low_then_high_s(s);
        !s ##1 s;
    endsequence
    wr_oe_high_a: assert property (!o_write_enable_n |-> o_output_enable_n)
        else $error("output enable low in write");
    rd_no_drive_a: assert property (!o_output_enable_n |-> !o_data_bus_oe && o_write_enable_n)
        else $error("data driven in read");
    wr_addr_hold_a: assert property (!o_chip_select_n && !o_write_enable_n |->
        $stable(o_addr_bus) && o_data_bus_oe)
        else $error("address moved in write");
    wr_data_end_a: assert property ($rose(o_write_enable_n) |->
        $stable(o_data_bus) && $stable(o_addr_bus) && o_data_bus_oe)
        else $error("data not held at write end");
    wr_len_a: assert property ($fell(o_write_enable_n) |=> low_then_high_s(o_write_enable_n))
        else $error("write strobe length");
    sel_len_a: assert property ($fell(o_chip_select_n) |=> low_then_high_s(o_chip_select_n))
        else $error("select strobe length");
    addr_setup_a: assert property ($fell(o_chip_select_n) |-> $stable(o_addr_bus))
        else $error("address not set up");
    busy_block_a: assert property (!i_store_busy_n [*8] |-> o_chip_select_n)
        else $error("access while busy");
    recov_wait_a: assert property ($fell(o_chip_select_n) |-> hi_cnt_q >= RECOVERY_CYC)
        else $error("access inside recovery");
    pin_pull_a: assert property (o_store_busy_n_oe |-> o_chip_select_n)
        else $error("access while pulling busy");
endmodule
bind nvsc_ctrl nvsc_ctrl_monitor #(.RECOVERY_CYC(RECOVERY_CYC)) i_mon (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .o_addr_bus(o_addr_bus),
    .o_chip_select_n(o_chip_select_n), .o_output_enable_n(o_output_enable_n),
    .o_write_enable_n(o_write_enable_n), .o_data_bus(o_data_bus),
    .o_data_bus_oe(o_data_bus_oe), .i_store_busy_n(i_store_busy_n),
    .o_store_busy_n_oe(o_store_busy_n_oe));
`default_nettype wire

//--- bench/nvsc_sram_model.sv
/* behavioural nonvolatile sram with store and recall sequencing
   assumes sampling on the bench clock */
`default_nettype none
module nvsc_sram_model #(
    parameter int STORE_CYC = 20,
    parameter int RECALL_CYC = 12,
    parameter int PUP_CYC = 30,
    parameter int DELAY_CYC = 4,
    parameter int REC_CYC = 4
) (
    input wire logic        i_ref_clk,
    input wire logic [14:0] i_addr_bus,
    input wire logic        i_chip_select_n,
    input wire logic        i_output_enable_n,
    input wire logic        i_write_enable_n,
    input wire logic [7:0]  i_data_bus,
    input wire logic        i_store_busy_n,
    input wire logic        i_power_ok,
    output logic      [7:0] o_data_bus,
    output logic            o_busy_low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [32768];
    logic [13:0] seq_tab [5] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F};
    logic [7:0]  last_q = 8'h00;
    logic [14:0] ra_q = 15'h0000;
    logic [2:0]  seq_q = 3'h0;
    logic        rd_q = 1'b0;
    logic        wflag_q = 1'b0;
    logic        auto_q = 1'b1;
    logic        pwr_q = 1'b1;
    int          busy_q = PUP_CYC;
    int          rec_q = 0;
    int          req_q = 0;
    int          n_store = 0;
    int          n_recall = 0;
    wire logic   rd = !i_chip_select_n && !i_output_enable_n && i_write_enable_n && busy_q == 0
                      && rec_q == 0 && i_power_ok;
    assign o_data_bus = rd ? mem[i_addr_bus] : (rd_q ? last_q : ~last_q);
    assign o_busy_low = busy_q != 0;
    always @(posedge i_ref_clk) begin
        rd_q <= rd;
        ra_q <= i_addr_bus;
        req_q <= (!i_store_busy_n && busy_q == 0) ? req_q + 1 : 0;
        pwr_q <= i_power_ok;
        if (rd) last_q <= mem[i_addr_bus];
        if (rec_q != 0) rec_q <= rec_q - 1;
        if (pwr_q != i_power_ok) begin
            wflag_q <= 1'b0;
            seq_q <= 3'h0;
            if (i_power_ok) begin
                busy_q <= PUP_CYC;
                n_recall <= n_recall + 1;
            end else if (auto_q && wflag_q) begin
                busy_q <= STORE_CYC;
                n_store <= n_store + 1;
            end
        end else if (busy_q != 0) begin
            busy_q <= busy_q - 1;
            if (busy_q == 1) rec_q <= REC_CYC;
        end else if (!i_power_ok) begin
            seq_q <= 3'h0;
        end else if (req_q == DELAY_CYC && wflag_q) begin
            busy_q <= STORE_CYC;
            n_store <= n_store + 1;
            wflag_q <= 1'b0;
        end else if (rec_q == 0 && !i_chip_select_n && !i_write_enable_n && i_store_busy_n) begin
            mem[i_addr_bus] <= i_data_bus;
            wflag_q <= 1'b1;
            seq_q <= 3'h0;
        end else if (rd_q && !rd && seq_q == 3'h5) begin
            seq_q <= 3'h0;
            case (ra_q[13:0])
                14'h0FC0: begin busy_q <= STORE_CYC; n_store <= n_store + 1; wflag_q <= 1'b0; end
                14'h0C63: begin busy_q <= RECALL_CYC; n_recall <= n_recall + 1; wflag_q <= 1'b0; end
                14'h0B45: auto_q <= 1'b0;
                14'h0B46: auto_q <= 1'b1;
                default: ;
            endcase
        end else if (rd_q && !rd) seq_q <= (ra_q[13:0] == seq_tab[seq_q]) ? seq_q + 3'h1 : 3'h0;
    end
endmodule
`default_nettype wire

//--- bench/test_nvsc_ctrl.sv
/* register-level test of the controller against the sram model
   assumes the monitor is bound from its own file */
`default_nettype none
module test_nvsc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  ra = 4'h0;
    logic [7:0]  rwd = 8'h00;
    logic        rwr = 1'b0;
    logic        rrd = 1'b0;
    logic [7:0]  rdata, dq_ctl, dq_dev, got;
    logic [14:0] abus;
    logic        cs_n, oe_n, we_n, dq_oe, sb_oe, sb_out, dev_low;
    logic        pwr_ok = 1'b1;
    // open-drain busy pin: either side may pull it low, pull-up otherwise
    wire logic   sb_pin = !(dev_low || (sb_oe && !sb_out));
    wire logic [7:0] dq = dq_oe ? dq_ctl : dq_dev;
    int          n_errors = 0;
    int          num_checks = 0;
    int          s0;
    logic [14:0] adr [2] = '{15'h1234, 15'h7FFF};
    logic [7:0]  dat [2] = '{8'hA5, 8'h3C};
    nvsc_ctrl #(.RECOVERY_CYC(16'h0008)) i_dut (.i_ref_clk(clk), .i_rstn(rstn),
        .i_reg_addr(ra), .i_reg_wdata(rwd), .i_reg_wr(rwr), .i_reg_rd(rrd),
        .o_reg_rdata(rdata), .o_addr_bus(abus), .o_chip_select_n(cs_n),
        .o_output_enable_n(oe_n), .o_write_enable_n(we_n), .i_data_bus(dq),
        .o_data_bus(dq_ctl), .o_data_bus_oe(dq_oe), .i_store_busy_n(sb_pin),
        .o_store_busy_n(sb_out), .o_store_busy_n_oe(sb_oe));
    nvsc_sram_model i_dev (.i_ref_clk(clk), .i_addr_bus(abus), .i_chip_select_n(cs_n),
        .i_output_enable_n(oe_n), .i_write_enable_n(we_n), .i_data_bus(dq),
        .i_store_busy_n(sb_pin), .i_power_ok(pwr_ok), .o_data_bus(dq_dev),
        .o_busy_low(dev_low));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a;
        rwd <= d;
        rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        ra <= a;
        rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1 d = rdata;
    endtask
    // issue a command and poll the active flag until idle
    task automatic cmd(input logic [2:0] c);
        logic [7:0] st;
        reg_wr(4'h0, {5'h00, c});
        for (int i = 0; i < 400; i++) begin
            reg_rd(4'h3, st);
            if (!st[0]) return;
        end
        check(st, 8'h00);
    endtask
    task automatic set_addr(input logic [14:0] a);
        reg_wr(4'h1, a[7:0]);
        reg_wr(4'h5, {1'b0, a[14:8]});
    endtask
    // supply dip long enough for a store, then power-up recall and recovery
    task automatic power_dip;
        @(posedge clk);
        pwr_ok <= 1'b0;
        repeat (40) @(posedge clk);
        pwr_ok <= 1'b1;
        repeat (120) @(posedge clk);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (60) @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            set_addr(adr[i]);
            reg_wr(4'h2, dat[i]);
            cmd(3'h2);
        end
        for (int i = 0; i < 2; i++) begin
            set_addr(adr[i]);
            cmd(3'h1);
            reg_rd(4'h4, got);
            check(got, dat[i]);
        end
        s0 = i_dev.n_store;
        cmd(3'h7);
        check(8'(i_dev.n_store - s0), 8'h01);
        cmd(3'h7);
        check(8'(i_dev.n_store - s0), 8'h01);
        cmd(3'h3);
        check(8'(i_dev.n_store - s0), 8'h02);
        cmd(3'h4);
        check(8'(i_dev.n_recall), 8'h01);
        cmd(3'h5);
        check({7'h00, i_dev.auto_q}, 8'h00);
        s0 = i_dev.n_store;
        cmd(3'h2);
        power_dip;
        check(8'(i_dev.n_store - s0), 8'h00);
        cmd(3'h6);
        check({7'h00, i_dev.auto_q}, 8'h01);
        cmd(3'h2);
        power_dip;
        check(8'(i_dev.n_store - s0), 8'h01);
        cmd(3'h1);
        reg_rd(4'h4, got);
        check(got, dat[1]);
        reg_rd(4'h3, got);
        check(got & 8'h05, 8'h00);
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish;
    end
endmodule
`default_nettype wire

//--- inc/nvsc_map.svh
/*
 * Constants of the nonvolatile SRAM controller: software sequence addresses,
 * timing figures in ns and the derived counts at the 40 MHz design clock.
 * Assumes it is included by bare name from the controller sources.
 */
`ifndef NVSC_MAP_SVH
`define NVSC_MAP_SVH

`define NVSC_CLK_PERIOD_NS      25
`define NVSC_SEQ_ADDR_0         14'h0E38
`define NVSC_SEQ_ADDR_1         14'h31C7
`define NVSC_SEQ_ADDR_2         14'h03E0
`define NVSC_SEQ_ADDR_3         14'h3C1F
`define NVSC_SEQ_ADDR_4         14'h303F
`define NVSC_SEQ_STORE          14'h0FC0
`define NVSC_SEQ_RECALL         14'h0C63
`define NVSC_SEQ_AS_OFF         14'h0B45
`define NVSC_SEQ_AS_ON          14'h0B46
// bus phase lengths in ns
`define NVSC_ACCESS_NS          35
`define NVSC_SETUP_NS           50
`define NVSC_ACCESS_CYC         ((`NVSC_ACCESS_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
`define NVSC_SETUP_CYC          ((`NVSC_SETUP_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
// recovery after the busy pin returns high
`define NVSC_RECOVERY_NS        20000
`define NVSC_RECOVERY_CYC       ((`NVSC_RECOVERY_NS + `NVSC_CLK_PERIOD_NS - 1) / `NVSC_CLK_PERIOD_NS)
// longest wait for the busy pin to fall after a command
`define NVSC_BUSY_WAIT_CYC      64
// software register indices
`define NVSC_REG_CTRL           4'h0
`define NVSC_REG_ADDR           4'h1
`define NVSC_REG_WDATA          4'h2
`define NVSC_REG_STATUS         4'h3
`define NVSC_REG_RDATA          4'h4
`define NVSC_REG_ADDR_HI        4'h5
// command codes in the control register
`define NVSC_CMD_READ           3'h1
`define NVSC_CMD_WRITE          3'h2
`define NVSC_CMD_STORE          3'h3
`define NVSC_CMD_RECALL         3'h4
`define NVSC_CMD_AS_OFF         3'h5
`define NVSC_CMD_AS_ON          3'h6
`define NVSC_CMD_HW_STORE       3'h7

`endif

//--- inc/nvsc_pkg.sv
/*
 * Types of the nonvolatile SRAM controller.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package nvsc_pkg;
    typedef enum logic [2:0] {
        NVSC_IDLE  = 3'h0,
        NVSC_SETUP = 3'h1,
        NVSC_STRB  = 3'h2,
        NVSC_HOLD  = 3'h3,
        NVSC_BWAIT = 3'h4,
        NVSC_BUSY  = 3'h5,
        NVSC_RECOV = 3'h6
    } nvsc_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [3:0] idx;
        logic       write;
        logic       done;
    } nvsc_cyc_t;

    typedef struct packed {
        logic [2:0] stages;
        logic       level;
    } nvsc_sync_t;

    typedef struct packed {
        nvsc_state_t state;
        logic [2:0]  cmd;
        logic [2:0]  seq_idx;
        logic [14:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic [15:0] timer;
        logic        err;
        logic [7:0]  bus_rdata;
        logic        use_pin;
    } nvsc_ctl_t;
endpackage
`default_nettype wire

//--- verilog/nvsc_ctrl.sv
/*
 * Host-side controller for a 32K x 8 SRAM with nonvolatile shadow copy.
 * Software writes commands over a plain register port; the controller runs
 * asynchronous SRAM cycles, six-read software sequences and the busy-pin
 * store request, and waits out the device's busy and recovery periods.
 * Assumes the busy pin has a pull-up on the board and that the register
 * master keeps to one strobe per cycle.
 */
// The implementer's own choices: the address-and-strobe port and the register addresses.
`include "nvsc_map.svh"
`default_nettype none
module nvsc_ctrl #(
    parameter logic [15:0] RECOVERY_CYC = 16'(`NVSC_RECOVERY_CYC)
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    // register port
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    // device address and control
    output logic      [14:0] o_addr_bus,
    output logic             o_chip_select_n,
    output logic             o_output_enable_n,
    output logic             o_write_enable_n,
    // device data bus
    input  wire logic [7:0]  i_data_bus,
    output logic      [7:0]  o_data_bus,
    output logic             o_data_bus_oe,
    // device store busy pin, open drain
    input  wire logic        i_store_busy_n,
    output logic             o_store_busy_n,
    output logic             o_store_busy_n_oe
);
    nvsc_pkg::nvsc_ctl_t s_q;
    nvsc_pkg::nvsc_ctl_t s_d;
    logic                busy_lvl;
    logic                cmd_go;
    logic                is_seq;
    logic [13:0]         seq_addr;

    nvsc_sync u_busy_sync (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_pin     (i_store_busy_n),
        .o_level   (busy_lvl)
    );

    assign cmd_go = i_reg_wr && (i_reg_addr == `NVSC_REG_CTRL) && (i_reg_wdata[2:0] != 3'h0);
    assign is_seq = (s_q.cmd == `NVSC_CMD_STORE) || (s_q.cmd == `NVSC_CMD_RECALL) ||
                    (s_q.cmd == `NVSC_CMD_AS_OFF) || (s_q.cmd == `NVSC_CMD_AS_ON);

    // address of the current sequence step
    always_comb begin
        seq_addr = `NVSC_SEQ_ADDR_0;
        unique case (s_q.seq_idx)
            3'h0: seq_addr = `NVSC_SEQ_ADDR_0;
            3'h1: seq_addr = `NVSC_SEQ_ADDR_1;
            3'h2: seq_addr = `NVSC_SEQ_ADDR_2;
            3'h3: seq_addr = `NVSC_SEQ_ADDR_3;
            3'h4: seq_addr = `NVSC_SEQ_ADDR_4;
            default: begin
                unique case (s_q.cmd)
                    `NVSC_CMD_STORE:  seq_addr = `NVSC_SEQ_STORE;
                    `NVSC_CMD_RECALL: seq_addr = `NVSC_SEQ_RECALL;
                    `NVSC_CMD_AS_OFF: seq_addr = `NVSC_SEQ_AS_OFF;
                    default:          seq_addr = `NVSC_SEQ_AS_ON;
                endcase
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.bus_rdata = 8'h00;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `NVSC_REG_CTRL:   s_d.bus_rdata = {5'h00, s_q.cmd};
                `NVSC_REG_ADDR:   s_d.bus_rdata = s_q.addr[7:0];
                `NVSC_REG_WDATA:  s_d.bus_rdata = s_q.wdata;
                `NVSC_REG_STATUS: s_d.bus_rdata = {5'h00, s_q.err, ~busy_lvl,
                                    (s_q.state != nvsc_pkg::NVSC_IDLE)};
                `NVSC_REG_RDATA:  s_d.bus_rdata = s_q.rdata;
                `NVSC_REG_ADDR_HI: s_d.bus_rdata = {1'b0, s_q.addr[14:8]};
                default:          s_d.bus_rdata = 8'h00;
            endcase
        end
        if (i_reg_wr && s_q.state == nvsc_pkg::NVSC_IDLE) begin
            if (i_reg_addr == `NVSC_REG_ADDR) s_d.addr[7:0] = i_reg_wdata;
            if (i_reg_addr == `NVSC_REG_ADDR_HI) s_d.addr[14:8] = i_reg_wdata[6:0];
            if (i_reg_addr == `NVSC_REG_WDATA) s_d.wdata = i_reg_wdata;
        end
        unique case (s_q.state)
            nvsc_pkg::NVSC_IDLE: begin
                // a command is taken only while the device is not busy
                if (cmd_go && busy_lvl) begin
                    s_d.cmd     = i_reg_wdata[2:0];
                    s_d.seq_idx = 3'h0;
                    s_d.err     = 1'b0;
                    s_d.timer   = 16'h0000;
                    if (i_reg_wdata[2:0] == `NVSC_CMD_HW_STORE) begin
                        s_d.use_pin = 1'b1;
                        s_d.state   = nvsc_pkg::NVSC_BWAIT;
                    end else begin
                        s_d.state = nvsc_pkg::NVSC_SETUP;
                    end
                end else if (cmd_go) begin
                    s_d.err = 1'b1;
                end else if (!busy_lvl) begin
                    // device-started store or power-up recall
                    s_d.state = nvsc_pkg::NVSC_BUSY;
                end
            end
            nvsc_pkg::NVSC_SETUP: begin
                // address settles before any strobe
                s_d.timer = s_q.timer + 16'h0001;
                if (s_q.timer == 16'(`NVSC_SETUP_CYC - 1)) begin
                    s_d.timer = 16'h0000;
                    s_d.state = nvsc_pkg::NVSC_STRB;
                end
            end
            nvsc_pkg::NVSC_STRB: begin
                // read strobe long enough for access, write strobe for data setup
                s_d.timer = s_q.timer + 16'h0001;
                if (s_q.timer == 16'(`NVSC_SETUP_CYC - 1)) begin
                    s_d.timer = 16'h0000;
                    s_d.rdata = i_data_bus;
                    s_d.state = nvsc_pkg::NVSC_HOLD;
                end
            end
            nvsc_pkg::NVSC_HOLD: begin
                if (is_seq && s_q.seq_idx != 3'h5) begin
                    s_d.seq_idx = s_q.seq_idx + 3'h1;
                    s_d.state   = nvsc_pkg::NVSC_SETUP;
                end else if (s_q.cmd == `NVSC_CMD_STORE || s_q.cmd == `NVSC_CMD_RECALL) begin
                    s_d.state = nvsc_pkg::NVSC_BWAIT;
                end else begin
                    s_d.state = nvsc_pkg::NVSC_IDLE;
                end
            end
            nvsc_pkg::NVSC_BWAIT: begin
                // the device may skip a pin store without a prior write
                s_d.timer = s_q.timer + 16'h0001;
                if (!busy_lvl) begin
                    s_d.timer = 16'h0000;
                    s_d.state = nvsc_pkg::NVSC_BUSY;
                end else if (s_q.timer == 16'(`NVSC_BUSY_WAIT_CYC)) begin
                    s_d.timer   = 16'h0000;
                    s_d.use_pin = 1'b0;
                    s_d.state   = nvsc_pkg::NVSC_RECOV;
                end
            end
            nvsc_pkg::NVSC_BUSY: begin
                // own pull is released on the first cycle in NVSC_BUSY, once the synchronised pin reads low
                s_d.use_pin = 1'b0;
                if (busy_lvl && !s_q.use_pin) begin
                    s_d.timer = 16'h0000;
                    s_d.state = nvsc_pkg::NVSC_RECOV;
                end
            end
            nvsc_pkg::NVSC_RECOV: begin
                s_d.timer = s_q.timer + 16'h0001;
                if (!busy_lvl) begin
                    s_d.state = nvsc_pkg::NVSC_BUSY;
                end else if (s_q.timer >= RECOVERY_CYC - 16'h0001) begin
                    s_d.timer = 16'h0000;
                    s_d.state = nvsc_pkg::NVSC_IDLE;
                end
            end
            default: s_d.state = nvsc_pkg::NVSC_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            s_q.state     <= nvsc_pkg::NVSC_RECOV;
            s_q.cmd       <= 3'h0;
            s_q.seq_idx   <= 3'h0;
            s_q.addr      <= 15'h0000;
            s_q.wdata     <= 8'h00;
            s_q.rdata     <= 8'h00;
            s_q.timer     <= 16'h0000;
            s_q.err       <= 1'b0;
            s_q.bus_rdata <= 8'h00;
            s_q.use_pin   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    logic cyc_act;
    logic cyc_wr;
    assign cyc_act = (s_q.state == nvsc_pkg::NVSC_STRB);
    assign cyc_wr  = (s_q.cmd == `NVSC_CMD_WRITE);

    assign o_reg_rdata = s_q.bus_rdata;
    // software sequences decode the low 14 bits; top bit kept low
    assign o_addr_bus = is_seq ? {1'b0, seq_addr} : s_q.addr;
    assign o_chip_select_n = !(cyc_act);
    assign o_output_enable_n = !(cyc_act && !cyc_wr);
    assign o_write_enable_n = !(cyc_act && cyc_wr && busy_lvl);
    assign o_data_bus = s_q.wdata;
    assign o_data_bus_oe = cyc_wr && (s_q.state == nvsc_pkg::NVSC_SETUP ||
                           s_q.state == nvsc_pkg::NVSC_STRB || s_q.state == nvsc_pkg::NVSC_HOLD);
    assign o_store_busy_n = 1'b0;
    assign o_store_busy_n_oe = s_q.use_pin;
endmodule
`default_nettype wire

//--- verilog/nvsc_sync.sv
/*
 * Three-stage input synchroniser for the device's busy pin.
 * Assumes the input is asynchronous to i_ref_clk.
 */
`default_nettype none
module nvsc_sync (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    // pin and result
    input  wire logic i_pin,
    output logic      o_level
);
    nvsc_pkg::nvsc_sync_t s_q;
    nvsc_pkg::nvsc_sync_t s_d;

    always_comb begin
        s_d        = s_q;
        s_d.stages = {s_q.stages[1:0], i_pin};
        // change only once the second and third stages agree
        if (s_q.stages[1] == s_q.stages[2]) begin
            s_d.level = s_q.stages[2];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            s_q <= '{stages: 3'h7, level: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_level = s_q.level;
endmodule
`default_nettype wire
